// ==== rtl/zca_zone.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Aux writes ignored unless pin function none
// - Jam: three auto-clear tries, then stop
// - Stopped zone resumes once sensor clears
// - Retry only on zero-to-one register transition
// - Accumulate bit holds any arriving carton
// - Arrival differs from departure while occupied
// - Arrival presents carton's current tracking words
// - Incremented release count releases, re-accumulates
// - Release while downstream full is remembered
// - Leaving sensor sets departure to arrival
// - Clearing accumulate bit releases held carton
// - Holding words attach only on count release
// - Both holding words zero keep tracking
// - Both 0xFFFF clear; single 0xFFFF stored
module zca_zone import zca_pkg::*; #(
  parameter int JAM_CYCLES = JAM_CYCLES_DEF,
  parameter int PAUSE_CYCLES = PAUSE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic zone_sensor,
  input wire logic downstream_full,
  input wire logic [1:0] aux_func_none,
  input wire logic [15:0] in_track1,
  input wire logic [15:0] in_track2,
  output logic motor_run,
  output logic [1:0] aux_out,
  output logic [15:0] out_track1,
  output logic [15:0] out_track2,
  output logic out_track_valid,
  output logic jam_stopped,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  if (JAM_CYCLES < 1 || PAUSE_CYCLES < 1) begin : g_bad_timing
    $error("zca_zone: jam and pause spans must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tracking merge of one word on a count release
  function automatic logic [15:0] merge_word(input logic [15:0] cur, input logic [15:0] hold,
                                             input logic keep, input logic clr);
    if (keep) begin
      merge_word = cur;
    end else if (clr) begin
      merge_word = RST_WORD;
    end else begin
      merge_word = hold;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin inputs
  logic sensor_blk, ds_full;
  logic [1:0] aux_none;

  zca_sync #(.W(4)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin_in({aux_func_none, downstream_full, zone_sensor}),
    .level({aux_none, ds_full, sensor_blk})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register state
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic accum_q, accum_d;
  logic [15:0] rel_req_q, rel_req_d;
  logic [15:0] set1_q, set1_d, set2_q, set2_d;
  logic retry_q, retry_d;
  logic [1:0] aux_q, aux_d;
  logic [IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d;
  logic irq_q, irq_d;
  logic take_wr, take_rd, retry_pulse;

  // Zone state
  zca_zone_t zst_q, zst_d;
  logic [15:0] rel_cnt_q, rel_cnt_d, arr_q, arr_d, dep_q, dep_d;
  logic [15:0] cur1_q, cur1_d, cur2_q, cur2_d;
  logic [15:0] o1_q, o1_d, o2_q, o2_d;
  logic ov_q, ov_d, run_q, run_d;
  logic ev_arr, ev_dep, ev_rel;
  logic rel_pend, jam_men, jam_stop, jam_evt;
  logic hold_keep, hold_clr;

  zca_jam #(
    .JAM_CYCLES(JAM_CYCLES),
    .PAUSE_CYCLES(PAUSE_CYCLES),
    .TRIES(AUTO_TRIES)
  ) u_jam (
    .clk(clk),
    .resetn(resetn),
    // A zone held back by a full downstream is waiting, not jammed
    .run_req((zst_q == ZS_RUN) && !ds_full),
    .sensor_blocked(sensor_blk),
    .retry_pulse(retry_pulse),
    .motor_en(jam_men),
    .stopped(jam_stop),
    .jam_evt(jam_evt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state per access
  assign take_wr = avs_write && !wait_q;
  // Read data is latched while the request still waits, so it stands when the wait drops
  assign take_rd = avs_read && wait_q;
  assign retry_pulse = take_wr && (avs_address == REG_JAM_RETRY)
                       && avs_writedata[0] && !retry_q;

  always_comb begin
    wait_d = !((avs_read || avs_write) && wait_q);
    rdata_d = rdata_q;
    accum_d = accum_q;
    rel_req_d = rel_req_q;
    set1_d = set1_q;
    set2_d = set2_q;
    retry_d = retry_q;
    aux_d = aux_q;
    ien_d = ien_q;
    ist_d = ist_q;
    if (take_rd) begin
      case (avs_address)
        REG_ACCUM_CTRL: rdata_d = {31'h0, accum_q};
        REG_RELEASE_REQ: rdata_d = {16'h0, rel_req_q};
        REG_RELEASE_CNT: rdata_d = {16'h0, rel_cnt_q};
        REG_ARRIVAL_CNT: rdata_d = {16'h0, arr_q};
        REG_DEPART_CNT: rdata_d = {16'h0, dep_q};
        REG_CUR_TRACK1: rdata_d = {16'h0, cur1_q};
        REG_CUR_TRACK2: rdata_d = {16'h0, cur2_q};
        REG_SET_TRACK1: rdata_d = {16'h0, set1_q};
        REG_SET_TRACK2: rdata_d = {16'h0, set2_q};
        REG_JAM_RETRY: rdata_d = {31'h0, retry_q};
        REG_AUX_OUT: rdata_d = {30'h0, aux_q};
        REG_ZONE_STATUS: rdata_d = {27'h0, ds_full, sensor_blk, jam_stop, zst_q};
        REG_IRQ_STATUS: rdata_d = {28'h0, ist_q};
        REG_IRQ_ENABLE: rdata_d = {28'h0, ien_q};
        default: rdata_d = 32'h0;
      endcase
    end
    if (take_wr) begin
      case (avs_address)
        REG_ACCUM_CTRL: accum_d = avs_writedata[0];
        REG_RELEASE_REQ: rel_req_d = avs_writedata[15:0];
        REG_SET_TRACK1: set1_d = avs_writedata[15:0];
        REG_SET_TRACK2: set2_d = avs_writedata[15:0];
        REG_JAM_RETRY: retry_d = avs_writedata[0];
        REG_AUX_OUT: begin
          for (int i = 0; i < 2; i++) begin
            if (aux_none[i]) begin
              aux_d[i] = avs_writedata[i];
            end
          end
        end
        REG_IRQ_ENABLE: ien_d = avs_writedata[IRQ_W-1:0];
        REG_IRQ_CLEAR: ist_d = ist_q & ~avs_writedata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // New events win over a clear in the same cycle
    ist_d = ist_d | {ev_rel, jam_evt, ev_dep, ev_arr};
    irq_d = |(ist_d & ien_d);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      accum_q <= 1'b0;
      rel_req_q <= RST_WORD;
      set1_q <= RST_WORD;
      set2_q <= RST_WORD;
      retry_q <= 1'b0;
      aux_q <= 2'h0;
      ien_q <= RST_IRQ;
      ist_q <= RST_IRQ;
      irq_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      accum_q <= accum_d;
      rel_req_q <= rel_req_d;
      set1_q <= set1_d;
      set2_q <= set2_d;
      retry_q <= retry_d;
      aux_q <= aux_d;
      ien_q <= ien_d;
      ist_q <= ist_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Zone sequencer
  // A pending release stays pending until served, so a full downstream only delays it
  assign rel_pend = (rel_req_q != rel_cnt_q);
  // Both holding words must carry the same marker for keep or clear
  assign hold_keep = (set1_q == TRACK_KEEP) && (set2_q == TRACK_KEEP);
  assign hold_clr = (set1_q == TRACK_CLEAR) && (set2_q == TRACK_CLEAR);

  always_comb begin
    zst_d = zst_q;
    rel_cnt_d = rel_cnt_q;
    arr_d = arr_q;
    dep_d = dep_q;
    cur1_d = cur1_q;
    cur2_d = cur2_q;
    o1_d = o1_q;
    o2_d = o2_q;
    ov_d = 1'b0;
    ev_arr = 1'b0;
    ev_dep = 1'b0;
    ev_rel = 1'b0;
    case (zst_q)
      ZS_EMPTY: begin
        if (sensor_blk) begin
          arr_d = arr_q + 16'd1;
          cur1_d = in_track1;
          cur2_d = in_track2;
          ev_arr = 1'b1;
          zst_d = accum_q ? ZS_HELD : ZS_RUN;
        end
      end
      ZS_HELD: begin
        if (!sensor_blk) begin
          dep_d = arr_q;
          ev_dep = 1'b1;
          zst_d = ZS_EMPTY;
        end else if (!accum_q) begin
          // Cancelled hold leaves the holding words unused
          zst_d = ZS_RUN;
        end else if (rel_pend && !ds_full) begin
          cur1_d = merge_word(cur1_q, set1_q, hold_keep, hold_clr);
          cur2_d = merge_word(cur2_q, set2_q, hold_keep, hold_clr);
          rel_cnt_d = rel_cnt_q + 16'd1;
          ev_rel = 1'b1;
          zst_d = ZS_RUN;
        end
      end
      ZS_RUN: begin
        if (!sensor_blk) begin
          dep_d = arr_q;
          o1_d = cur1_q;
          o2_d = cur2_q;
          ov_d = 1'b1;
          ev_dep = 1'b1;
          zst_d = ZS_EMPTY;
        end
      end
      default: zst_d = ZS_EMPTY;
    endcase
    run_d = (zst_d == ZS_RUN) && jam_men && !ds_full;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      zst_q <= ZS_EMPTY;
      rel_cnt_q <= RST_WORD;
      arr_q <= RST_WORD;
      dep_q <= RST_WORD;
      cur1_q <= RST_WORD;
      cur2_q <= RST_WORD;
      o1_q <= RST_WORD;
      o2_q <= RST_WORD;
      ov_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      zst_q <= zst_d;
      rel_cnt_q <= rel_cnt_d;
      arr_q <= arr_d;
      dep_q <= dep_d;
      cur1_q <= cur1_d;
      cur2_q <= cur2_d;
      o1_q <= o1_d;
      o2_q <= o2_d;
      ov_q <= ov_d;
      run_q <= run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign motor_run = run_q;
  assign aux_out = aux_q;
  assign out_track1 = o1_q;
  assign out_track2 = o2_q;
  assign out_track_valid = ov_q;
  assign jam_stopped = jam_stop;
  assign irq = irq_q;
endmodule // zca_zone

// ==== rtl/zca_pkg.sv ====
package zca_pkg;
  localparam int DATA_W = 16;

  // Register word offsets on the Avalon-MM slave
  localparam logic [3:0] REG_ACCUM_CTRL = 4'h0;
  localparam logic [3:0] REG_RELEASE_REQ = 4'h1;
  localparam logic [3:0] REG_RELEASE_CNT = 4'h2;
  localparam logic [3:0] REG_ARRIVAL_CNT = 4'h3;
  localparam logic [3:0] REG_DEPART_CNT = 4'h4;
  localparam logic [3:0] REG_CUR_TRACK1 = 4'h5;
  localparam logic [3:0] REG_CUR_TRACK2 = 4'h6;
  localparam logic [3:0] REG_SET_TRACK1 = 4'h7;
  localparam logic [3:0] REG_SET_TRACK2 = 4'h8;
  localparam logic [3:0] REG_JAM_RETRY = 4'h9;
  localparam logic [3:0] REG_AUX_OUT = 4'ha;
  localparam logic [3:0] REG_ZONE_STATUS = 4'hb;
  localparam logic [3:0] REG_IRQ_STATUS = 4'hc;
  localparam logic [3:0] REG_IRQ_CLEAR = 4'hd;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'he;

  // Interrupt bit positions
  localparam int IRQ_ARRIVAL_BIT = 0;
  localparam int IRQ_DEPART_BIT = 1;
  localparam int IRQ_JAM_BIT = 2;
  localparam int IRQ_RELEASE_BIT = 3;
  localparam int IRQ_W = 4;

  // Special holding-word values
  localparam logic [15:0] TRACK_KEEP = 16'h0000;
  localparam logic [15:0] TRACK_CLEAR = 16'hffff;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_IRQ = 4'h0;

  // Timing
  localparam longint CLK_HZ = 40000000;
  localparam int JAM_TIME_MS = 4;
  localparam int PAUSE_TIME_MS = 1;
  localparam int JAM_CYCLES_DEF = int'((CLK_HZ * JAM_TIME_MS) / 1000);
  localparam int PAUSE_CYCLES_DEF = int'((CLK_HZ * PAUSE_TIME_MS) / 1000);
  localparam int AUTO_TRIES = 3;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {ZS_EMPTY, ZS_HELD, ZS_RUN} zca_zone_t;
  typedef enum logic [1:0] {JS_WATCH, JS_PAUSE, JS_TRY, JS_STOP} zca_jam_t;
endpackage

// ==== rtl/zca_sync.sv ====
`timescale 1ns/1ps
// Pin input filter: three stages, a change is accepted once stages two and three agree
module zca_sync import zca_pkg::*; #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] lvl_d;

  if (W < 1) begin : g_bad_width
    $error("zca_sync: W must be at least 1");
  end

  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
endmodule // zca_sync

// ==== rtl/zca_jam.sv ====
`timescale 1ns/1ps
// Sensor jam supervisor: auto-clear tries, then stop until the sensor clears or a retry pulse arrives
module zca_jam import zca_pkg::*; #(
  parameter int JAM_CYCLES = JAM_CYCLES_DEF,
  parameter int PAUSE_CYCLES = PAUSE_CYCLES_DEF,
  parameter int TRIES = AUTO_TRIES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run_req,
  input wire logic sensor_blocked,
  input wire logic retry_pulse,
  output logic motor_en,
  output logic stopped,
  output logic jam_evt
);
  localparam int CW = $clog2(JAM_CYCLES + PAUSE_CYCLES + 1);
  localparam logic [CW-1:0] JAM_LAST = CW'(JAM_CYCLES - 1);
  localparam logic [CW-1:0] PAUSE_LAST = CW'(PAUSE_CYCLES - 1);
  localparam logic [1:0] TRY_LAST = 2'(TRIES - 1);

  zca_jam_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [1:0] tries_q, tries_d;
  logic men_q, men_d, evt_q, evt_d;
  logic stop_q, stop_d;

  if (JAM_CYCLES < 1 || PAUSE_CYCLES < 1 || TRIES < 1 || TRIES > 3) begin : g_bad_param
    $error("zca_jam: bad timing or try count");
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + CW'(1);
    tries_d = tries_q;
    evt_d = 1'b0;
    case (st_q)
      JS_WATCH: begin
        if (!(run_req && sensor_blocked)) begin
          cnt_d = '0;
        end else if (cnt_q == JAM_LAST) begin
          st_d = JS_PAUSE;
          cnt_d = '0;
          tries_d = '0;
        end
      end
      JS_PAUSE: begin
        if (!sensor_blocked) begin
          st_d = JS_WATCH;
          cnt_d = '0;
        end else if (cnt_q == PAUSE_LAST) begin
          st_d = JS_TRY;
          cnt_d = '0;
        end
      end
      JS_TRY: begin
        if (!sensor_blocked) begin
          st_d = JS_WATCH;
          cnt_d = '0;
        end else if (cnt_q == JAM_LAST) begin
          cnt_d = '0;
          if (tries_q >= TRY_LAST) begin
            st_d = JS_STOP;
            evt_d = 1'b1;
          end else begin
            st_d = JS_PAUSE;
            tries_d = tries_q + 2'd1;
          end
        end
      end
      JS_STOP: begin
        cnt_d = '0;
        if (!sensor_blocked) begin
          st_d = JS_WATCH;
        end else if (retry_pulse) begin
          // A single extra try lands straight back here if it fails
          st_d = JS_PAUSE;
          tries_d = TRY_LAST;
        end
      end
      default: begin
        st_d = JS_WATCH;
        cnt_d = '0;
      end
    endcase
    men_d = (st_d == JS_WATCH) || (st_d == JS_TRY);
    stop_d = (st_d == JS_STOP);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= JS_WATCH;
      cnt_q <= '0;
      tries_q <= '0;
      men_q <= 1'b1;
      evt_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tries_q <= tries_d;
      men_q <= men_d;
      evt_q <= evt_d;
      stop_q <= stop_d;
    end
  end

  assign motor_en = men_q;
  assign stopped = stop_q;
  assign jam_evt = evt_q;
endmodule // zca_jam

// ==== testbench/zca_zone_assertions.sv ====
`timescale 1ns/1ps
module zca_zone_checker import zca_pkg::*; #(
  parameter int JAM_CYCLES = JAM_CYCLES_DEF,
  parameter int PAUSE_CYCLES = PAUSE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic zone_sensor,
  input wire logic downstream_full,
  input wire logic motor_run,
  input wire logic [1:0] aux_out,
  input wire logic out_track_valid,
  input wire logic jam_stopped
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_req_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Filter plus motor register lag stays under six cycles
  sequence s_full_settled;
    downstream_full [*6];
  endsequence
  property p_wait_answer;
    s_req_taken |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("request not answered");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer held too long");
  property p_unmapped;
    s_req_taken ##0 (avs_read && avs_address == 4'hf) |=> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_aux_cause;
    aux_out != $past(aux_out)
      |-> $past(avs_write && !avs_waitrequest && avs_address == REG_AUX_OUT);
  endproperty
  a_aux_cause: assert property (p_aux_cause) else $error("aux output changed alone");
  property p_jam_rise;
    $rose(jam_stopped) |-> zone_sensor ##[1:2] !motor_run;
  endproperty
  a_jam_rise: assert property (p_jam_rise) else $error("bad jam stop");
  property p_jam_fall;
    $fell(jam_stopped) |-> !zone_sensor
      || $past(avs_write && !avs_waitrequest && avs_address == REG_JAM_RETRY);
  endproperty
  a_jam_fall: assert property (p_jam_fall) else $error("jam ended while blocked");
  property p_full_hold;
    s_full_settled |-> !motor_run;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("ran into full downstream");
  property p_depart;
    $rose(out_track_valid) |-> !zone_sensor ##1 !out_track_valid;
  endproperty
  a_depart: assert property (p_depart) else $error("bad departure pulse");
endmodule // zca_zone_checker

bind zca_zone zca_zone_checker #(.JAM_CYCLES(JAM_CYCLES), .PAUSE_CYCLES(PAUSE_CYCLES))
  zca_zone_checker_inst (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .zone_sensor, .downstream_full, .motor_run, .aux_out, .out_track_valid,
  .jam_stopped);

// ==== testbench/zca_belt_model.sv ====
`timescale 1ns/1ps
// Conveyor side: carton on the sensor, downstream state and pin setup
module zca_belt_model (
  input wire logic clk,
  output logic zone_sensor,
  output logic downstream_full,
  output logic [1:0] aux_func_none,
  output logic [15:0] in_track1,
  output logic [15:0] in_track2
);
  initial begin
    zone_sensor = 1'b0;
    downstream_full = 1'b0;
    aux_func_none = 2'b00;
    in_track1 = 16'h5a5a;
    in_track2 = 16'ha5a5;
  end
  task automatic arrive(input logic [15:0] t1, input logic [15:0] t2);
    @(posedge clk);
    in_track1 <= t1;
    in_track2 <= t2;
    zone_sensor <= 1'b1;
  endtask
  // Words mean nothing once the carton is gone, so they are scrambled
  task automatic leave();
    @(posedge clk);
    zone_sensor <= 1'b0;
    in_track1 <= ~in_track1;
    in_track2 <= ~in_track2;
  endtask
  task automatic set_pins(input logic full, input logic [1:0] none);
    @(posedge clk);
    downstream_full <= full;
    aux_func_none <= none;
  endtask
endmodule // zca_belt_model

// ==== testbench/zca_zone_bench.sv ====
`timescale 1ns/1ps
module zca_zone_bench import zca_pkg::*;;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic zone_sensor, downstream_full, motor_run, out_track_valid, jam_stopped, irq;
  logic [1:0] aux_func_none, aux_out;
  logic [15:0] in_track1, in_track2, out_track1, out_track2;
  logic [15:0] cap1 = 16'h0bad;
  logic [15:0] cap2 = 16'h0bad;
  int fail_count = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  zca_belt_model belt (.clk, .zone_sensor, .downstream_full, .aux_func_none, .in_track1,
    .in_track2);
  zca_zone #(.JAM_CYCLES(20), .PAUSE_CYCLES(10)) zca_zone_inst (.clk, .resetn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .zone_sensor,
    .downstream_full, .aux_func_none, .in_track1, .in_track2, .motor_run, .aux_out,
    .out_track1, .out_track2, .out_track_valid, .jam_stopped, .irq);
  always @(posedge clk) begin
    if (out_track_valid === 1'b1) begin
      cap1 <= out_track1;
      cap2 <= out_track2;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Pin inputs pass a filter, so counters are polled rather than timed
  task automatic poll(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    repeat (40) begin
      bus(1'b0, a, 32'h0, q);
      if (q === e) break;
    end
    chk(q, e);
  endtask
  task automatic wait_motor(input logic v);
    repeat (60) begin
      if (motor_run === v) break;
      @(posedge clk);
    end
    chk({31'h0, motor_run}, {31'h0, v});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(REG_ACCUM_CTRL, 32'h0);
    rd_chk(REG_RELEASE_CNT, 32'h0);
    rd_chk(REG_IRQ_STATUS, 32'h0);
    rd_chk(4'hf, 32'h0);
    wr(REG_ARRIVAL_CNT, 32'h5);
    rd_chk(REG_ARRIVAL_CNT, 32'h0);
    wr(REG_IRQ_ENABLE, 32'h1);
  endtask
  task automatic t_release(input logic [31:0] n, input logic [15:0] t1, t2, s1, s2, e1, e2,
    input logic full);
    wr(REG_ACCUM_CTRL, 32'h1);
    belt.arrive(t1, t2);
    poll(REG_ARRIVAL_CNT, n);
    rd_chk(REG_DEPART_CNT, n - 1);
    rd_chk(REG_CUR_TRACK1, {16'h0, t1});
    rd_chk(REG_CUR_TRACK2, {16'h0, t2});
    wait_motor(1'b0);
    rd_chk(REG_ZONE_STATUS, 32'h9);
    wr(REG_SET_TRACK1, {16'h0, s1});
    wr(REG_SET_TRACK2, {16'h0, s2});
    belt.set_pins(full, 2'b00);
    rd_chk(REG_RELEASE_CNT, n - 1);
    wr(REG_RELEASE_REQ, n);
    if (full) begin
      repeat (10) @(posedge clk);
      chk({31'h0, motor_run}, 32'h0);
      rd_chk(REG_ZONE_STATUS, 32'h19);
      rd_chk(REG_RELEASE_CNT, n - 1);
      belt.set_pins(1'b0, 2'b00);
    end
    wait_motor(1'b1);
    belt.leave();
    poll(REG_DEPART_CNT, n);
    rd_chk(REG_RELEASE_CNT, n);
    chk({16'h0, cap1}, {16'h0, e1});
    chk({16'h0, cap2}, {16'h0, e2});
  endtask
  task automatic t_irq();
    chk({31'h0, irq}, 32'h1);
    rd_chk(REG_IRQ_STATUS, 32'hb);
    wr(REG_IRQ_ENABLE, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(REG_IRQ_ENABLE, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(REG_IRQ_CLEAR, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd_chk(REG_IRQ_STATUS, 32'ha);
  endtask
  task automatic t_cancel();
    belt.arrive(16'h0011, 16'h0022);
    poll(REG_ARRIVAL_CNT, 32'h4);
    wr(REG_SET_TRACK1, 32'h0abc);
    wr(REG_SET_TRACK2, 32'h0def);
    wr(REG_ACCUM_CTRL, 32'h0);
    wait_motor(1'b1);
    belt.leave();
    poll(REG_DEPART_CNT, 32'h4);
    chk({16'h0, cap1}, 32'h0011);
    chk({16'h0, cap2}, 32'h0022);
  endtask
  task automatic t_jam();
    int ran;
    ran = 0;
    wr(REG_IRQ_ENABLE, 32'h4);
    belt.arrive(16'h0077, 16'h0088);
    repeat (300) begin
      if (jam_stopped === 1'b1) break;
      @(posedge clk);
    end
    chk({31'h0, jam_stopped}, 32'h1);
    // The interrupt line follows jam_stopped by one cycle, rising together with the status bit
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(REG_JAM_RETRY, 32'h1);
    wait_motor(1'b1);
    wait_motor(1'b0);
    repeat (80) begin
      @(posedge clk);
      if (motor_run === 1'b1) ran++;
    end
    chk(ran, 0);
    wr(REG_JAM_RETRY, 32'h0);
    wr(REG_JAM_RETRY, 32'h1);
    wait_motor(1'b1);
    wait_motor(1'b0);
    belt.leave();
    poll(REG_DEPART_CNT, 32'h5);
    chk({31'h0, jam_stopped}, 32'h0);
  endtask
  task automatic t_aux();
    belt.set_pins(1'b0, 2'b01);
    repeat (6) @(posedge clk);
    wr(REG_AUX_OUT, 32'h3);
    chk({30'h0, aux_out}, 32'h1);
    belt.set_pins(1'b0, 2'b11);
    repeat (6) @(posedge clk);
    wr(REG_AUX_OUT, 32'h3);
    chk({30'h0, aux_out}, 32'h3);
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_release(1, 16'h1234, 16'h5678, 16'hffff, 16'h00ab, 16'hffff, 16'h00ab, 1'b1);
    t_release(2, 16'h0033, 16'h0044, 16'h0, 16'h0, 16'h0033, 16'h0044, 1'b0);
    t_release(3, 16'h0055, 16'h0066, 16'hffff, 16'hffff, 16'h0, 16'h0, 1'b0);
    t_irq();
    t_cancel();
    t_jam();
    t_aux();
    wrap_up();
  end
endmodule // zca_zone_bench
